// file: src/msi_pkg.sv
// Purpose: shared constants for the module status indicator block
// Assumes: 125 MHz system clock
// Notes:   timing counts derive from the clock period
package msi_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned TICK_CYC       = (TICK_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned BLINK_ON_S     = 1;
    localparam int unsigned BLINK_OFF_S    = 2;
    localparam int unsigned MS_PER_S       = 1000;
    localparam logic [15:0] BLINK_ON_TK    = 16'(BLINK_ON_S * MS_PER_S / TICK_MS);
    localparam logic [15:0] BLINK_OFF_TK   = 16'(BLINK_OFF_S * MS_PER_S / TICK_MS);
    localparam logic [15:0] PS_ON_MIN_TK   = 16'h0001;
    localparam logic [15:0] PS_OFF_MIN_TK  = 16'h0001;
    localparam int unsigned TICK_W         = 17;

    typedef enum logic [4:0] {
        NS_OFF     = 5'h01,
        NS_SEARCH  = 5'h02,
        NS_IDLE    = 5'h04,
        NS_PSAVE   = 5'h08,
        NS_ACTIVE  = 5'h10
    } msi_net_t;

    localparam logic [1:0] NET_OFF        = 2'h0;
    localparam logic [1:0] NET_UNREG      = 2'h1;
    localparam logic [1:0] NET_REG        = 2'h2;
    localparam logic [1:0] NET_REG_PSAVE  = 2'h3;
endpackage

// file: src/msi_tick.sv
// Purpose: fixed-rate tick from the module clock
// Assumes: one clock, async active-low reset
// Notes:   one-cycle pulse every PERIOD cycles, TICK_CYC by default
module msi_tick
    import msi_pkg::*;
#(
    parameter int unsigned PERIOD = TICK_CYC
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      tick_o
);
    logic [TICK_W-1:0] cnt_ff;
    localparam logic [TICK_W-1:0] LAST = TICK_W'(PERIOD - 1);

    // free-running divider
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (cnt_ff == LAST);
            if (cnt_ff == LAST)
                cnt_ff <= '0;
            else
                cnt_ff <= cnt_ff + TICK_W'(1);
        end
    end
endmodule

// file: src/msi_top.sv
// Purpose: network status, software ready and thermal alert indicators
// Assumes: inputs synchronous to CLOCK_I, 125 MHz
// Notes:   network status pattern on the first general purpose pad while PAD1_GPIO_MODE_I is low
// Notes on behaviour
// - network indicator off when off, steady on unregistered, blinking when registered
// - registered idle without power saving blinks one second on, two off
// - power saving blink uses durations supplied by network conditions
// - first general purpose pad carries network indicator by default after reset
// - software ready held low until boot completes
// - software ready high once commands accepted; host waits for it
// - thermal alert output high when configured and threshold reached
module msi_top
    import msi_pkg::*;
#(
    parameter int unsigned TICK_PERIOD = TICK_CYC
)
(
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [1:0]  NET_STATE_I,
    input  wire logic [15:0] PS_ON_TICKS_I,
    input  wire logic [15:0] PS_OFF_TICKS_I,
    input  wire logic        PAD1_GPIO_MODE_I,
    input  wire logic        PAD1_GPIO_OUT_I,
    input  wire logic        PAD1_GPIO_OE_N_I,
    input  wire logic        BOOT_DONE_I,
    input  wire logic        THERMAL_ALERT_CMD_I,
    input  wire logic        TEMP_MAX_REACHED_I,
    output logic             NETWORK_STATUS_INDICATOR_O,
    output logic             PAD1_OUT_O,
    output logic             PAD1_OE_N_O,
    output logic             SOFTWARE_READY_INDICATOR_O,
    output logic             THERMAL_ALERT_O
);
    logic        tick;
    msi_net_t    state_ff;
    msi_net_t    nxt_state;
    logic [15:0] cnt_ff;
    logic        phase_on_ff;
    logic        led;
    logic [15:0] on_len;
    logic [15:0] off_len;
    logic        blinking;

    msi_tick #(.PERIOD(TICK_PERIOD)) msi_tick_inst
    (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESET_N_I),
        .tick_o  (tick)
    );

    // mode decode
    always_comb
    begin
        case (NET_STATE_I)
            NET_OFF:       nxt_state = NS_OFF;
            NET_UNREG:     nxt_state = NS_SEARCH;
            NET_REG:       nxt_state = NS_IDLE;
            NET_REG_PSAVE: nxt_state = NS_PSAVE;
            default:       nxt_state = NS_OFF;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            state_ff <= NS_OFF;
        else
            state_ff <= nxt_state;
    end

    // period selection, power saving lengths floored at one tick
    always_comb
    begin
        on_len  = BLINK_ON_TK;
        off_len = BLINK_OFF_TK;
        if (state_ff == NS_PSAVE)
        begin
            on_len  = (PS_ON_TICKS_I < PS_ON_MIN_TK) ? PS_ON_MIN_TK : PS_ON_TICKS_I;
            off_len = (PS_OFF_TICKS_I < PS_OFF_MIN_TK) ? PS_OFF_MIN_TK : PS_OFF_TICKS_I;
        end
    end

    assign blinking = (state_ff == NS_IDLE) || (state_ff == NS_PSAVE);

    // blink phase counter
    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            cnt_ff      <= '0;
            phase_on_ff <= 1'b1;
        end
        else if (!blinking || (state_ff != nxt_state))
        begin
            cnt_ff      <= '0;
            phase_on_ff <= 1'b1;
        end
        else if (tick)
        begin
            if (phase_on_ff && (cnt_ff >= on_len - 16'h0001))
            begin
                cnt_ff      <= '0;
                phase_on_ff <= 1'b0;
            end
            else if (!phase_on_ff && (cnt_ff >= off_len - 16'h0001))
            begin
                cnt_ff      <= '0;
                phase_on_ff <= 1'b1;
            end
            else
                cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    always_comb
    begin
        case (state_ff)
            NS_OFF:    led = 1'b0;
            NS_SEARCH: led = 1'b1;
            NS_IDLE:   led = phase_on_ff;
            NS_PSAVE:  led = phase_on_ff;
            default:   led = 1'b0;
        endcase
    end

    // outputs
    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            NETWORK_STATUS_INDICATOR_O <= 1'b0;
            PAD1_OUT_O                 <= 1'b0;
            PAD1_OE_N_O                <= 1'b0;
        end
        else
        begin
            NETWORK_STATUS_INDICATOR_O <= led;
            PAD1_OUT_O  <= PAD1_GPIO_MODE_I ? PAD1_GPIO_OUT_I : led;
            PAD1_OE_N_O <= PAD1_GPIO_MODE_I ? PAD1_GPIO_OE_N_I : 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            SOFTWARE_READY_INDICATOR_O <= 1'b0;
        else
            SOFTWARE_READY_INDICATOR_O <= BOOT_DONE_I;
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            THERMAL_ALERT_O <= 1'b0;
        else
            THERMAL_ALERT_O <= THERMAL_ALERT_CMD_I && TEMP_MAX_REACHED_I;
    end

    property p_off_dark;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_ff == NS_OFF) |=> !NETWORK_STATUS_INDICATOR_O;
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("indicator lit while off");

    property p_unreg_on;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_ff == NS_SEARCH) |=> NETWORK_STATUS_INDICATOR_O;
    endproperty
    a_unreg_on: assert property (p_unreg_on) else $error("indicator dark while unregistered");

    property p_idle_on_len;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_ff == NS_IDLE && phase_on_ff && tick && cnt_ff == BLINK_ON_TK - 16'h0001
         && nxt_state == NS_IDLE) |=> !phase_on_ff;
    endproperty
    a_idle_on_len: assert property (p_idle_on_len) else $error("on phase length wrong");

    property p_idle_off_len;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_ff == NS_IDLE && !phase_on_ff && cnt_ff < BLINK_OFF_TK - 16'h0001
         && nxt_state == NS_IDLE) |=> !phase_on_ff;
    endproperty
    a_idle_off_len: assert property (p_idle_off_len) else $error("off phase ended early");

    property p_psave_blink;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (state_ff == NS_PSAVE) |=> (NETWORK_STATUS_INDICATOR_O == $past(phase_on_ff));
    endproperty
    a_psave_blink: assert property (p_psave_blink) else $error("power save blink wrong");

    property p_pad_default;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        !PAD1_GPIO_MODE_I |=> (PAD1_OUT_O == NETWORK_STATUS_INDICATOR_O) && !PAD1_OE_N_O;
    endproperty
    a_pad_default: assert property (p_pad_default) else $error("pad not carrying indicator");

    property p_ready_low;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        !BOOT_DONE_I |=> !SOFTWARE_READY_INDICATOR_O;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready before boot done");

    property p_ready_high;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        $rose(BOOT_DONE_I) |=> SOFTWARE_READY_INDICATOR_O;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready not raised");

    property p_thermal;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (THERMAL_ALERT_CMD_I && TEMP_MAX_REACHED_I) |=> THERMAL_ALERT_O;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal alert missing");

    property p_tick_gate;
        @(posedge CLOCK_I) disable iff (!RESET_N_I)
        (!tick && blinking && state_ff == nxt_state) |=> $stable(cnt_ff);
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("count moved without tick");
endmodule

// file: test/msi_host_model.sv
// Purpose: host and led driver facing the status indicators
// Assumes: levels taken on the rising clock edge
// Notes:   lit and dark run lengths counted in clock cycles
module msi_host_model
(
    input  wire logic  clk_i,
    input  wire logic  led_i,
    input  wire logic  ready_i,
    input  wire logic  cfg_req_i,
    output logic       cfg_cmd_o,
    output logic [15:0] on_len_o,
    output logic [15:0] off_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        led_ff;
    logic [15:0] run_ff;
    initial
    begin
        cfg_cmd_o = 1'b0;
        led_ff = 1'b0;
        run_ff = 16'h0000;
    end
    // configure command only once ready seen
    always @(posedge clk_i)
        cfg_cmd_o <= cfg_req_i & ready_i;
    always @(posedge clk_i)
    begin
        if (led_i === led_ff)
            run_ff <= run_ff + 16'h0001;
        else
        begin
            if (led_ff)
                on_len_o <= run_ff;
            else
                off_len_o <= run_ff;
            run_ff <= 16'h0001;
        end
        led_ff <= led_i;
    end
endmodule

// file: test/msi_top_tb.sv
// Purpose: self-checking bench for the status indicators
// Assumes: short tick period of 4 cycles
// Notes:   inputs driven on the falling edge
module msi_top_tb import msi_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TP = 4;
    logic clk = 1'b0, rst_n = 1'b0, g_mode = 1'b0, g_out = 1'b0, g_oe_n = 1'b0;
    logic boot = 1'b0, temp = 1'b0, req = 1'b0, tcmd;
    logic [1:0] net = NET_OFF;
    logic [15:0] ps_on = 16'h0003, ps_off = 16'h0005, on_len, off_len;
    logic ind, p_out, p_oe_n, rdy, alrt;
    int fail_count = 0;
    int tests_run = 0;
    always #4 clk = ~clk;
    msi_top #(.TICK_PERIOD(TP)) msi_top_inst (.CLOCK_I(clk), .RESET_N_I(rst_n),
        .NET_STATE_I(net), .PS_ON_TICKS_I(ps_on), .PS_OFF_TICKS_I(ps_off),
        .PAD1_GPIO_MODE_I(g_mode), .PAD1_GPIO_OUT_I(g_out), .PAD1_GPIO_OE_N_I(g_oe_n),
        .BOOT_DONE_I(boot), .THERMAL_ALERT_CMD_I(tcmd), .TEMP_MAX_REACHED_I(temp),
        .NETWORK_STATUS_INDICATOR_O(ind), .PAD1_OUT_O(p_out), .PAD1_OE_N_O(p_oe_n),
        .SOFTWARE_READY_INDICATOR_O(rdy), .THERMAL_ALERT_O(alrt));
    msi_host_model msi_host_model_inst (.clk_i(clk), .led_i(ind), .ready_i(rdy),
        .cfg_req_i(req), .cfg_cmd_o(tcmd), .on_len_o(on_len), .off_len_o(off_len));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_off();
        chk("ready in reset", 16'h0000, rdy);
        rst_n = 1'b1;
        cyc(4);
        chk("ind off", 16'h0000, ind);
        chk("pad oe_n", 16'h0000, p_oe_n);
        chk("ready boot", 16'h0000, rdy);
    endtask
    task automatic t_unreg();
        net = NET_UNREG;
        cyc(3);
        chk("ind on", 16'h0001, ind);
        cyc(60);
        chk("ind steady", 16'h0001, ind);
        chk("pad ind", 16'h0001, p_out);
    endtask
    task automatic t_idle();
        net = NET_REG;
        cyc(24100);
        chk("on len", 16'(BLINK_ON_TK * TP), on_len);
        chk("off len", 16'(BLINK_OFF_TK * TP), off_len);
    endtask
    task automatic t_psave();
        net = NET_REG_PSAVE;
        cyc(200);
        chk("ps on len", 16'(3 * TP), on_len);
        chk("ps off len", 16'(5 * TP), off_len);
        ps_on = 16'h0000;
        cyc(100);
        chk("ps on floor", 16'(PS_ON_MIN_TK * TP), on_len);
    endtask
    task automatic t_ready();
        req = 1'b1;
        temp = 1'b1;
        cyc(3);
        chk("no alert unset", 16'h0000, alrt);
        boot = 1'b1;
        cyc(2);
        chk("ready", 16'h0001, rdy);
        cyc(3);
        chk("alert", 16'h0001, alrt);
        temp = 1'b0;
        cyc(2);
        chk("alert clear", 16'h0000, alrt);
    endtask
    task automatic t_gpio();
        g_mode = 1'b1;
        g_out = 1'b1;
        g_oe_n = 1'b1;
        cyc(2);
        chk("gpio oe_n", 16'h0001, p_oe_n);
        g_oe_n = 1'b0;
        g_out = 1'b0;
        cyc(2);
        chk("gpio out", 16'h0000, p_out);
        net = NET_UNREG;
        g_mode = 1'b0;
        cyc(3);
        chk("pad back", 16'h0001, p_out);
        chk("pad oe back", 16'h0000, p_oe_n);
    endtask
    task automatic t_reset();
        temp = 1'b1;
        cyc(4);
        chk("alert pre", 16'h0001, alrt);
        rst_n = 1'b0;
        cyc(1);
        chk("ind in reset", 16'h0000, ind);
        chk("ready in reset again", 16'h0000, rdy);
        chk("alert in reset", 16'h0000, alrt);
        rst_n = 1'b1;
        cyc(1);
        chk("ready after reset", 16'h0001, rdy);
        chk("ind after reset", 16'h0000, ind);
        cyc(1);
        chk("alert waits ready", 16'h0000, alrt);
        chk("ind unreg again", 16'h0001, ind);
        cyc(1);
        chk("alert after reset", 16'h0001, alrt);
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial
    begin
        cyc(12);
        t_off();
        t_unreg();
        t_idle();
        t_psave();
        t_ready();
        t_gpio();
        t_reset();
        close_out();
    end
endmodule
